// file: header_classifier.v
/*
  Classifies one received frame header as a management frame and
  checks it, giving a registered verdict one cycle after hdr_valid.
  Assumes header fields are stable while hdr_valid is high.
*/
`timescale 1ns/1ps
`include "inband_mgmt_consts.vh"

module header_classifier (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        mgmt_enable,
  input  wire        dest_check,
  input  wire [2:0]  port_sel,
  input  wire [15:0] mgmt_ethertype,
  input  wire [47:0] station_addr,
  input  wire        hdr_valid,
  input  wire [1:0]  hdr_port,
  input  wire [15:0] hdr_ethertype,
  input  wire [47:0] hdr_dest_addr,
  input  wire        hdr_tag_match,
  input  wire [15:0] hdr_format,
  input  wire [15:0] hdr_access_code,
  input  wire [15:0] hdr_length,
  output reg         verdict,
  output reg         tag_clear,
  output reg         dest_drop,
  output reg         err_fmt,
  output reg         err_code,
  output reg         err_size
);

  wire is_mgmt;

  // reserved port codes can never equal a 2-bit port number plus zero msb
  assign is_mgmt = mgmt_enable && ({1'b0, hdr_port} == port_sel) &&
                   (hdr_ethertype == mgmt_ethertype);

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      verdict   <= 1'b0;
      tag_clear <= 1'b0;
      dest_drop <= 1'b0;
      err_fmt   <= 1'b0;
      err_code  <= 1'b0;
      err_size  <= 1'b0;
    end else begin
      verdict   <= hdr_valid && is_mgmt;
      tag_clear <= hdr_tag_match;
      dest_drop <= dest_check && (hdr_dest_addr != station_addr);
      err_fmt   <= (hdr_format != `FORMAT_OK);
      err_code  <= (hdr_access_code != `CODE_READ) &&
                   (hdr_access_code != `CODE_WRITE);
      err_size  <= (hdr_length > `MAX_LEN);
    end
  end

endmodule // header_classifier

// file: inband_mgmt_consts.vh
/*
  Constants of the in-band management control block: register indexes,
  field positions, reset values and header check values.
  Assumes it is included by its bare name from the design files.
*/
`ifndef INBAND_MGMT_CONSTS_VH
`define INBAND_MGMT_CONSTS_VH

// register indexes; byte address is four times the index
`define CTRL_IDX     14'h0104
`define STAT_IDX     14'h0110
`define MAC_IDX      14'h0302
`define MAC_BYTES    14'h0006

// control register fields
`define ENA_BIT      31
`define DCHK_BIT     30
`define SMRST_BIT    29
`define RQ_HI        23
`define RQ_LO        22
`define PORT_HI      18
`define PORT_LO      16
`define ETYPE_HI     15
`define ETYPE_LO     0

`define RQ_RESET     2'h1
`define PORT_RESET   3'h0
`define ETYPE_RESET  16'h40FE
`define MAC_RESET    48'h0010_A1FF_0000

// status register fields
`define GOOD_BIT     31
`define RDONE_BIT    30
`define XDONE_BIT    29
`define EMAC_BIT     14
`define EFMT_BIT     13
`define ECODE_BIT    12
`define ECMD_BIT     11
`define ESIZE_BIT    10
`define POS_HI       6

// header check values
`define FORMAT_OK    16'h9800
`define CODE_READ    16'h0001
`define CODE_WRITE   16'h0002
`define MAX_LEN      16'h0140

// bus answers
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// file: inband_mgmt_frame_control.v
/*
  Control and status of in-band management access, with an AXI4-Lite
  register slave, the access state machine and the station address.
  Assumes the frame datapath presents header fields and event pulses
  synchronous to sys_clk, and the strap pin is stable around reset.
*/
// What this block does
// - enable bit loads the inverted strap level when reset ends
// - destination check on: frames not matching station address dropped
// - writing bit 29 restarts the access state machine; reads zero
// - bits 23:22 pick the response priority queue, reset 01
// - bits 18:16 pick the management port; codes 100-111 match none
// - bits 15:0 hold management EtherType, reset 0x40FE
// - status bit 31 set on a good management packet
// - status bit 30 set once the response packet is sent
// - status bit 29 set once all commands of a packet executed
// - tag-matching packet clears status bits 30, 29 and 14..10
// - status bit 14 set on destination mismatch while checking
// - status bit 13 set when access format is not 0x9800
// - status bit 12 set when access code is not 0x0001 or 0x0002
// - status bit 11 set on an unrecognised command code
// - packets over 320 bytes set bit 10 and get no response
// - while bit 11 is set bits 6:0 give the bad command position
// - station address is six byte registers from 0x0302, msb first
`timescale 1ns/1ps
`include "inband_mgmt_consts.vh"

module inband_mgmt_frame_control (
  input  wire        sys_clk,
  input  wire        reset,
  input  wire        indicator_strap_pin,
  // AXI4-Lite slave
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // frame datapath
  input  wire        hdr_valid,
  input  wire [1:0]  hdr_port,
  input  wire [15:0] hdr_ethertype,
  input  wire [47:0] hdr_dest_addr,
  input  wire        hdr_tag_match,
  input  wire [15:0] hdr_format,
  input  wire [15:0] hdr_access_code,
  input  wire [15:0] hdr_length,
  input  wire        cmd_error_valid,
  input  wire [6:0]  cmd_error_pos,
  input  wire        exec_done,
  input  wire        resp_sent,
  output reg         mgmt_execute,
  output reg         resp_request,
  output reg         frame_discard,
  output reg         engine_restart,
  output reg         frame_mgmt_enable,
  output reg  [1:0]  resp_queue,
  output reg  [2:0]  mgmt_port_sel
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_EXEC = 2'h1;
  localparam [1:0] ST_RESP = 2'h2;

  reg [1:0]  state;
  reg [1:0]  next_state;
  reg        dest_check;
  reg [15:0] mgmt_ethertype;
  reg        strap_done;
  reg [7:0]  mac_byte [0:5];
  reg [31:0] stat;
  reg [31:0] next_stat;
  reg [6:0]  cmd_pos;
  reg        next_execute;
  reg        next_resp_req;
  reg        next_discard;

  reg        aw_held;
  reg [15:0] aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [31:0] rd_value;
  reg        rd_hit;

  wire        verdict;
  wire        tag_clear;
  wire        dest_drop;
  wire        err_fmt;
  wire        err_code;
  wire        err_size;
  wire [47:0] station_addr;
  wire        do_write;
  wire        wr_ctrl;
  wire [13:0] wr_mac_off;
  wire        wr_mac;
  wire [13:0] rd_mac_off;

  assign station_addr = {mac_byte[0], mac_byte[1], mac_byte[2],
                         mac_byte[3], mac_byte[4], mac_byte[5]};

  header_classifier classifier (
    .sys_clk         (sys_clk),
    .reset           (reset),
    .mgmt_enable     (frame_mgmt_enable),
    .dest_check      (dest_check),
    .port_sel        (mgmt_port_sel),
    .mgmt_ethertype  (mgmt_ethertype),
    .station_addr    (station_addr),
    .hdr_valid       (hdr_valid),
    .hdr_port        (hdr_port),
    .hdr_ethertype   (hdr_ethertype),
    .hdr_dest_addr   (hdr_dest_addr),
    .hdr_tag_match   (hdr_tag_match),
    .hdr_format      (hdr_format),
    .hdr_access_code (hdr_access_code),
    .hdr_length      (hdr_length),
    .verdict         (verdict),
    .tag_clear       (tag_clear),
    .dest_drop       (dest_drop),
    .err_fmt         (err_fmt),
    .err_code        (err_code),
    .err_size        (err_size)
  );

  // write channel: address and data held separately, either order
  assign do_write   = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl    = (aw_addr[15:2] == `CTRL_IDX);
  assign wr_mac_off = aw_addr[15:2] - `MAC_IDX;
  assign wr_mac     = (wr_mac_off < `MAC_BYTES);
  assign rd_mac_off = s_axi_araddr[15:2] - `MAC_IDX;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held       <= 1'b0;
      aw_addr       <= 16'h0000;
      w_held        <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status is read-only, so a write to it is refused like a hole
        s_axi_bresp  <= (wr_ctrl || wr_mac) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // control register; the strap is caught on the first edge after reset
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strap_done        <= 1'b0;
      frame_mgmt_enable <= 1'b0;
      dest_check        <= 1'b0;
      resp_queue        <= `RQ_RESET;
      mgmt_port_sel     <= `PORT_RESET;
      mgmt_ethertype    <= `ETYPE_RESET;
      engine_restart    <= 1'b0;
    end else begin
      engine_restart <= 1'b0;
      if (!strap_done) begin
        strap_done        <= 1'b1;
        frame_mgmt_enable <= ~indicator_strap_pin;
      end else if (do_write && wr_ctrl) begin
        // only defined fields are stored; reserved bits are dropped
        if (w_strb[3]) begin
          frame_mgmt_enable <= w_data[`ENA_BIT];
          dest_check        <= w_data[`DCHK_BIT];
          engine_restart    <= w_data[`SMRST_BIT];
        end
        if (w_strb[2]) begin
          resp_queue    <= w_data[`RQ_HI:`RQ_LO];
          mgmt_port_sel <= w_data[`PORT_HI:`PORT_LO];
        end
        if (w_strb[1])
          mgmt_ethertype[15:8] <= w_data[15:8];
        if (w_strb[0])
          mgmt_ethertype[7:0] <= w_data[7:0];
      end
    end
  end

  // station address bytes, index 0 is the most significant
  localparam [47:0] MAC_INIT = `MAC_RESET;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_mac
      always @(posedge sys_clk or posedge reset) begin
        if (reset)
          mac_byte[gi] <= MAC_INIT[8 * (5 - gi) +: 8];
        else if (do_write && wr_mac && w_strb[0] &&
                 (wr_mac_off[2:0] == gi))
          mac_byte[gi] <= w_data[7:0];
      end
    end
  endgenerate

  // access state machine and status flags; a set beats a clear
  always @* begin
    next_state    = state;
    next_stat     = stat;
    next_execute  = 1'b0;
    next_resp_req = 1'b0;
    next_discard  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (verdict) begin
          if (tag_clear) begin
            next_stat[`RDONE_BIT] = 1'b0;
            next_stat[`XDONE_BIT] = 1'b0;
            next_stat[`EMAC_BIT:`ESIZE_BIT] = 5'h00;
          end
          if (dest_drop) begin
            next_stat[`EMAC_BIT] = 1'b1;
            next_discard = 1'b1;
          end else if (err_size) begin
            next_stat[`ESIZE_BIT] = 1'b1;
            next_discard = 1'b1;
          end else if (err_fmt || err_code) begin
            next_stat[`EFMT_BIT]  = err_fmt;
            next_stat[`ECODE_BIT] = err_code;
            next_resp_req = 1'b1;
            next_state    = ST_RESP;
          end else begin
            next_stat[`GOOD_BIT] = 1'b1;
            next_execute = 1'b1;
            next_state   = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (cmd_error_valid)
          next_stat[`ECMD_BIT] = 1'b1;
        if (exec_done) begin
          next_stat[`XDONE_BIT] = 1'b1;
          next_resp_req = 1'b1;
          next_state    = ST_RESP;
        end
      end
      ST_RESP: begin
        if (resp_sent) begin
          next_stat[`RDONE_BIT] = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (engine_restart) begin
      next_state    = ST_IDLE;
      next_execute  = 1'b0;
      next_resp_req = 1'b0;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state         <= ST_IDLE;
      stat          <= 32'h0000_0000;
      cmd_pos       <= 7'h00;
      mgmt_execute  <= 1'b0;
      resp_request  <= 1'b0;
      frame_discard <= 1'b0;
    end else begin
      state         <= next_state;
      stat          <= next_stat;
      mgmt_execute  <= next_execute;
      resp_request  <= next_resp_req;
      frame_discard <= next_discard;
      // first bad command of the packet is the one reported
      if (state == ST_EXEC && cmd_error_valid && !stat[`ECMD_BIT])
        cmd_pos <= cmd_error_pos;
    end
  end

  // read mux; reserved bits are zero
  always @* begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    if (s_axi_araddr[15:2] == `CTRL_IDX) begin
      rd_value[`ENA_BIT]           = frame_mgmt_enable;
      rd_value[`DCHK_BIT]          = dest_check;
      rd_value[`RQ_HI:`RQ_LO]      = resp_queue;
      rd_value[`PORT_HI:`PORT_LO]  = mgmt_port_sel;
      rd_value[`ETYPE_HI:`ETYPE_LO] = mgmt_ethertype;
    end else if (s_axi_araddr[15:2] == `STAT_IDX) begin
      rd_value[`GOOD_BIT:`XDONE_BIT] = stat[`GOOD_BIT:`XDONE_BIT];
      rd_value[`EMAC_BIT:`ESIZE_BIT] = stat[`EMAC_BIT:`ESIZE_BIT];
      if (stat[`ECMD_BIT])
        rd_value[`POS_HI:0] = cmd_pos;
    end else if (rd_mac_off < `MAC_BYTES) begin
      rd_value[7:0] = mac_byte[rd_mac_off[2:0]];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_value;
        s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // inband_mgmt_frame_control

// file: mgmt_ctrl_properties.sv
/* checker for inband_mgmt_frame_control: bus answers and frame pulses.
   bound to the top module; sees only its ports. */
`timescale 1ns/1ps
module mgmt_ctrl_props (
  input wire        sys_clk,
  input wire        reset,
  input wire [15:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        hdr_valid,
  input wire        exec_done,
  input wire        mgmt_execute,
  input wire        resp_request,
  input wire        frame_discard,
  input wire        engine_restart
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // write lands one edge after the take; bvalid is seen the edge after
  write_answer_a: assert property (
    wr_take |-> ##2 s_axi_bvalid) else $error("write answer missing");
  b_release_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b stuck");
  read_answer_a: assert property (
    ar_take |=> s_axi_rvalid && !s_axi_arready) else $error("no read data");
  restart_pulse_a: assert property (
    wr_take ##0 s_axi_awaddr == 16'h0410 && s_axi_wstrb[3] && s_axi_wdata[29]
    |-> ##2 engine_restart) else $error("restart pulse missing");
  exec_cause_a: assert property (
    mgmt_execute |-> $past(hdr_valid, 2)) else $error("execute without frame");
  exec_pulse_a: assert property (
    mgmt_execute |=> !mgmt_execute) else $error("execute too long");
  discard_cause_a: assert property (
    frame_discard |-> $past(hdr_valid, 2) && !resp_request && !mgmt_execute)
    else $error("bad discard");
  resp_cause_a: assert property (
    resp_request |-> $past(exec_done) || $past(hdr_valid, 2))
    else $error("response without cause");
endmodule // mgmt_ctrl_props

// file: mgmt_host_model.sv
/* far side: sends frame headers and answers execute and response pulses
   after lat cycles. assumes send() is called just after a clock edge. */
`timescale 1ns/1ps
module mgmt_host_model (
  input  wire         sys_clk,
  input  wire         reset,
  input  wire         mgmt_execute,
  input  wire         resp_request,
  output logic        hdr_valid,
  output wire  [1:0]  hdr_port,
  output wire  [15:0] hdr_ethertype,
  output wire  [47:0] hdr_dest_addr,
  output wire         hdr_tag_match,
  output wire  [15:0] hdr_format,
  output wire  [15:0] hdr_access_code,
  output wire  [15:0] hdr_length,
  output logic        cmd_error_valid,
  output logic [6:0]  cmd_error_pos,
  output logic        exec_done,
  output logic        resp_sent
);
  int           lat = 3;
  int           xc = 0;
  int           rc = 0;
  logic [6:0]   err_pos = 7'h00;
  logic [114:0] fields = '0;
  assign {hdr_port, hdr_ethertype, hdr_format, hdr_access_code,
          hdr_length, hdr_dest_addr, hdr_tag_match} = fields;
  initial begin
    {hdr_valid, cmd_error_valid, exec_done, resp_sent} = '0;
    cmd_error_pos = '0;
  end
  // tag always matches, so every acted frame clears old flags other than status bit 31
  task automatic send(input [1:0] p, input [15:0] et, fmt, code, len,
                      input [47:0] da);
    fields <= {p, et, fmt, code, len, da, 1'b1};
    hdr_valid <= 1;
    @(posedge sys_clk);
    hdr_valid <= 0;
    // released fields must not keep looking valid
    fields <= ~{p, et, fmt, code, len, da, 1'b1};
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      {cmd_error_valid, exec_done, resp_sent} <= '0;
      xc <= 0;
      rc <= 0;
    end else begin
      exec_done <= xc == 1;
      cmd_error_valid <= xc == 2 && err_pos != 0;
      cmd_error_pos <= xc == 2 ? err_pos : ~err_pos;
      resp_sent <= rc == 1;
      xc <= mgmt_execute ? lat : (xc > 0 ? xc - 1 : 0);
      rc <= resp_request ? lat : (rc > 0 ? rc - 1 : 0);
    end
  end
endmodule // mgmt_host_model

// file: tb.sv
/* bench for inband_mgmt_frame_control: AXI4-Lite tasks and host frames.
   assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
`include "inband_mgmt_consts.vh"
module tb;
  localparam [15:0] CTRL = {`CTRL_IDX, 2'b00};
  localparam [15:0] STAT = {`STAT_IDX, 2'b00};
  localparam [47:0] STN  = 48'h0210_A1FF_0000;
  logic        sys_clk = 0;
  logic        reset = 1;
  logic        indicator_strap_pin = 0;
  logic [15:0] s_axi_awaddr = '0;
  logic [15:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0;
  logic        s_axi_wvalid = 0;
  logic        s_axi_bready = 0;
  logic        s_axi_arvalid = 0;
  logic        s_axi_rready = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, hdr_valid, hdr_tag_match, cmd_error_valid;
  wire         exec_done, resp_sent, mgmt_execute, resp_request;
  wire         frame_discard, engine_restart, frame_mgmt_enable;
  wire [1:0]   s_axi_bresp, s_axi_rresp, hdr_port, resp_queue;
  wire [2:0]   mgmt_port_sel;
  wire [6:0]   cmd_error_pos;
  wire [15:0]  hdr_ethertype, hdr_format, hdr_access_code, hdr_length;
  wire [31:0]  s_axi_rdata;
  wire [47:0]  hdr_dest_addr;
  int          bad_count = 0;
  int          total_checks = 0;
  inband_mgmt_frame_control i_dut (.*);
  mgmt_host_model i_host (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 50) begin
      bad_count++;
      $display("[FAIL] %0t: no bus answer", $time);
      give_verdict();
    end
  endtask
  task automatic wr(input [15:0] a, input [31:0] d, input [1:0] er);
    int   n;
    logic ap;
    logic dp;
    n = 0;
    ap = 1;
    dp = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (ap || dp) begin
      tick(n);
      if (ap && s_axi_awready) begin
        ap = 0;
        s_axi_awvalid <= 0;
      end
      if (dp && s_axi_wready) begin
        dp = 0;
        s_axi_wvalid <= 0;
      end
    end
    do tick(n); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do tick(n); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do tick(n); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input [15:0] a, input [31:0] e, input [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask
  // frame outcomes take a variable time, so read until settled
  task automatic poll(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 20 && d !== e; i++)
      rd(STAT, d, r);
    chk(d, e);
    if (d !== e)
      give_verdict();
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    repeat (2) @(posedge sys_clk);
    chk(frame_mgmt_enable, 1);
    chk(resp_queue, 2'h1);
    chk(mgmt_port_sel, 3'h0);
    rchk(CTRL, 32'h8040_40FE, 2'h0);
    rchk(STAT, 32'h0000_0000, 2'h0);
    wr(CTRL, 32'hFFFF_FFFF, 2'h0);
    rchk(CTRL, 32'hC0C7_FFFF, 2'h0);
    chk(resp_queue, 2'h3);
    s_axi_wstrb <= 4'h2;
    wr(CTRL, 32'h0000_0000, 2'h0);
    s_axi_wstrb <= 4'hF;
    rchk(CTRL, 32'hC0C7_00FF, 2'h0);
    wr(STAT, 32'hFFFF_FFFF, 2'h2);
    rchk(16'h0500, 32'h0000_0000, 2'h2);
    rchk(16'h0C0C, 32'h0000_0010, 2'h0);
    wr(16'h0C08, 32'h0000_0002, 2'h0);
    wr(CTRL, 32'hC042_40FE, 2'h0);
    $display("test registers done");
    i_host.err_pos = 7'h05;
    i_host.send(0, 16'h40FE, 16'h9800, 1, 320, STN);
    poll(32'h0000_0000);
    i_host.send(2, 16'h40FE, 16'h9800, 1, 320, 48'h0010_A1FF_0000);
    poll(32'h0000_4000);
    i_host.send(2, 16'h40FE, 16'h9800, 1, 320, STN);
    poll(32'hE000_0805);
    // one byte over the limit, sent on purpose
    i_host.send(2, 16'h40FE, 16'h9800, 1, 321, STN);
    poll(32'h8000_0400);
    i_host.send(2, 16'h40FE, 16'h9801, 1, 320, STN);
    poll(32'hC000_2000);
    wr(CTRL, 32'h8042_40FE, 2'h0);
    i_host.send(2, 16'h40FE, 16'h9800, 3, 64, 48'h0);
    poll(32'hC000_1000);
    i_host.send(2, 16'h1234, 16'h9800, 2, 64, STN);
    poll(32'hC000_1000);
    i_host.err_pos = 7'h00;
    i_host.lat = 9;
    i_host.send(2, 16'h40FE, 16'h9800, 2, 64, STN);
    poll(32'hE000_0000);
    // restart mid-execution: the late exec_done must then be ignored
    i_host.lat = 30;
    i_host.send(2, 16'h40FE, 16'h9800, 2, 64, STN);
    wr(CTRL, 32'hA042_40FE, 2'h0);
    repeat (40) @(posedge sys_clk);
    rchk(STAT, 32'h8000_0000, 2'h0);
    $display("test frames done");
    indicator_strap_pin <= 1;
    reset <= 1;
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    repeat (2) @(posedge sys_clk);
    chk(frame_mgmt_enable, 0);
    rchk(CTRL, 32'h0040_40FE, 2'h0);
    i_host.send(0, 16'h40FE, 16'h9800, 2, 64, 48'h0010_A1FF_0000);
    poll(32'h0000_0000);
    $display("test strap done");
    give_verdict();
  end
endmodule // tb
bind inband_mgmt_frame_control mgmt_ctrl_props i_props (.*);
